/* design/mpct_regs.svh */
// register offsets, field positions and reset values of the timer
`ifndef MPCT_REGS_SVH
`define MPCT_REGS_SVH
// ============================================================
// register byte offsets
`define MPCT_OFS_CTRL   6'h00
`define MPCT_OFS_STAT   6'h04
`define MPCT_OFS_MASK   6'h08
`define MPCT_OFS_DMAE   6'h0C
`define MPCT_OFS_CNT    6'h10
`define MPCT_OFS_PSC    6'h14
`define MPCT_OFS_ARR    6'h18
`define MPCT_OFS_DEAD   6'h1C
`define MPCT_OFS_CH     6'h20
// ============================================================
// control fields
`define MPCT_CTRL_EN    0
`define MPCT_CTRL_MODE  1
`define MPCT_CTRL_FRZ   3
`define MPCT_CTRL_SLV   4
`define MPCT_CTRL_OPM   6
`define MPCT_CTRL_HALL  7
// ============================================================
// status, mask and dma enable fields
`define MPCT_ST_UPD     0
`define MPCT_ST_CH      1
`define MPCT_ST_TRG     5
`define MPCT_ST_HALL    6
// ============================================================
// channel configuration fields
`define MPCT_CFG_MODE   0
`define MPCT_CFG_POL    2
`define MPCT_CFG_FALL   3
`define MPCT_CFG_OE     4
// ============================================================
// reset values
`define MPCT_RST_CTRL   8'h00
`define MPCT_RST_ARR    16'hFFFF
`define MPCT_RST_PSC    16'h0000
`define MPCT_RST_DEAD   8'h00
`endif

/* design/mpct_pkg.sv */
// types shared by the timer top and its channels
package mpct_pkg;
  typedef enum logic [1:0] {
    MPCT_CNT_UP     = 2'h0,
    MPCT_CNT_DOWN   = 2'h1,
    MPCT_CNT_CENTER = 2'h2
  } mpct_cnt_mode_t;
  typedef enum logic [1:0] {
    MPCT_SLV_OFF    = 2'h0,
    MPCT_SLV_TRIG   = 2'h1,
    MPCT_SLV_EXTCLK = 2'h2,
    MPCT_SLV_ENC    = 2'h3
  } mpct_slave_t;
  typedef enum logic [1:0] {
    MPCT_CH_CAPTURE  = 2'h0,
    MPCT_CH_COMPARE  = 2'h1,
    MPCT_CH_PWM      = 2'h2,
    MPCT_CH_ONEPULSE = 2'h3
  } mpct_ch_mode_t;
  typedef struct packed {
    logic [7:0]      ctrl;
    logic [6:0]      status;
    logic [6:0]      mask;
    logic [6:0]      dmaen;
    logic [15:0]     cnt;
    logic [15:0]     psc;
    logic [15:0]     psc_cnt;
    logic [15:0]     arr;
    logic [7:0]      dead;
    logic [3:0][4:0] chcfg;
    logic            dir_up;
    logic            step;
    logic            upd;
    logic            trig_out;
    logic            irq;
    logic            dma_req;
    logic            waitrequest;
    logic [31:0]     rdata;
    logic            prev_trig;
    logic            prev_a;
    logic [2:0]      prev_hall;
    logic [3:0]      prev_cap;
  } mpct_top_t;
  typedef struct packed {
    logic [15:0] ccr;
    logic        evt;
    logic        ref_lvl;
    logic        applied;
    logic [7:0]  dt_cnt;
    logic        main_act;
    logic        comp_act;
    logic        out_p;
    logic        out_n;
  } mpct_ch_t;
endpackage

/* design/mpct_channel.sv */
// one capture/compare channel with complementary output and dead time
`timescale 1ns/1ps
module mpct_channel #(
  parameter bit HAS_COMP = 1'b1
) (
  input  logic                    clk,
  input  logic                    rst_n,
  input  mpct_pkg::mpct_ch_mode_t mode,
  input  logic                    pol,
  input  logic                    oe,
  input  logic [7:0]              dead,
  input  logic [15:0]             cnt,
  input  logic                    step,
  input  logic                    upd,
  input  logic                    cap_evt,
  input  logic                    ccr_wr,
  input  logic [15:0]             ccr_wdata,
  output logic [15:0]             ccr,
  output logic                    evt,
  output logic                    out_p,
  output logic                    out_n
);
  mpct_pkg::mpct_ch_t st_reg;
  mpct_pkg::mpct_ch_t st_next;
  logic               match;

  // ============================================================
  // channel behaviour
  always_comb
  begin
    st_next = st_reg;
    st_next.evt = 1'b0;
    match = step && (cnt == st_reg.ccr);
    if (ccr_wr)
      st_next.ccr = ccr_wdata;
    case (mode)
      mpct_pkg::MPCT_CH_CAPTURE:
      begin
        st_next.ref_lvl = 1'b0;
        // a capture beats a software write in the same cycle
        if (cap_evt)
        begin
          st_next.ccr = cnt;
          st_next.evt = 1'b1;
        end
      end
      mpct_pkg::MPCT_CH_COMPARE:
      begin
        if (match)
        begin
          st_next.ref_lvl = ~st_reg.ref_lvl;
          st_next.evt = 1'b1;
        end
      end
      mpct_pkg::MPCT_CH_PWM:
      begin
        // ccr 0 is never active, ccr above reload is always active
        st_next.ref_lvl = (cnt < st_reg.ccr);
        st_next.evt = match;
      end
      mpct_pkg::MPCT_CH_ONEPULSE:
      begin
        if (match)
        begin
          st_next.ref_lvl = 1'b1;
          st_next.evt = 1'b1;
        end
        if (upd)
          st_next.ref_lvl = 1'b0;
      end
      default:
        st_next.ref_lvl = 1'b0;
    endcase
    // both legs off for dead+1 cycles around every edge of ref
    if (st_reg.ref_lvl != st_reg.applied)
    begin
      st_next.applied = st_reg.ref_lvl;
      st_next.dt_cnt = dead;
      st_next.main_act = 1'b0;
      st_next.comp_act = 1'b0;
    end
    else if (st_reg.dt_cnt != 8'h00)
      st_next.dt_cnt = st_reg.dt_cnt - 8'h01;
    else
    begin
      st_next.main_act = st_reg.applied & oe;
      st_next.comp_act = ~st_reg.applied & oe & HAS_COMP;
    end
    st_next.out_p = st_next.main_act ^ pol;
    st_next.out_n = st_next.comp_act ^ pol;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign ccr   = st_reg.ccr;
  assign evt   = st_reg.evt;
  assign out_p = st_reg.out_p;
  assign out_n = st_reg.out_n;

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_ref_edge;
    st_reg.ref_lvl != st_reg.applied;
  endsequence
  sequence s_both_off;
    !st_reg.main_act && !st_reg.comp_act;
  endsequence

  a_dead_gap: assert property (s_ref_edge |=> s_both_off)
    else $error("output pair not blanked on ref edge");
  a_no_overlap: assert property (!(st_reg.main_act && st_reg.comp_act))
    else $error("both legs of the pair active");
  a_pwm_zero: assert property (
    mode == mpct_pkg::MPCT_CH_PWM && st_reg.ccr == 16'h0000 && !ccr_wr
    |=> !st_reg.ref_lvl)
    else $error("pwm with zero compare went active");
  a_cap_value: assert property (
    mode == mpct_pkg::MPCT_CH_CAPTURE && cap_evt
    |=> st_reg.ccr == $past(cnt) && st_reg.evt)
    else $error("capture did not store the count");
endmodule

/* design/mpct_timer.sv */
// timer top: avalon slave, prescaler, counter, linking, channels
//
// Design decisions made here: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "mpct_regs.svh"
// ============================================================
module mpct_timer #(
  parameter int NUM_CH   = 4,
  parameter bit HAS_COMP = 1'b1,
  parameter bit UP_ONLY  = 1'b0
) (
  input  logic              clk,
  input  logic              arst_n,
  input  logic [5:0]        avs_address,
  input  logic              avs_read,
  input  logic              avs_write,
  input  logic [31:0]       avs_writedata,
  input  logic [3:0]        avs_byteenable,
  output logic [31:0]       avs_readdata,
  output logic              avs_waitrequest,
  input  logic [NUM_CH-1:0] cap_in,
  input  logic              enc_a,
  input  logic              enc_b,
  input  logic [2:0]        hall_in,
  input  logic              trig_in,
  input  logic              dbg_halt,
  output logic [NUM_CH-1:0] ch_out,
  output logic [NUM_CH-1:0] ch_out_n,
  output logic              irq,
  output logic              dma_req,
  output logic              trig_out
);
  generate
    if (NUM_CH < 1 || NUM_CH > 4)
      $error("NUM_CH must lie between 1 and 4");
  endgenerate

  // ============================================================
  // reset release
  logic [1:0] rst_sync_reg;
  logic       rst_n;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_reg <= 2'h0;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  assign rst_n = rst_sync_reg[1];

  // ============================================================
  // state and combinational helpers
  mpct_pkg::mpct_top_t      st_reg;
  mpct_pkg::mpct_top_t      st_next;
  mpct_pkg::mpct_cnt_mode_t cmode;
  mpct_pkg::mpct_slave_t    slv;
  logic [5:0]               addr;
  logic [31:0]              wmask;
  logic [31:0]              wr_word;
  logic [31:0]              rd_word;
  logic [6:0]               set_bits;
  logic [6:0]               clr_bits;
  logic                     req;
  logic                     acc_wr;
  logic                     cnt_wr;
  logic                     frozen;
  logic                     run;
  logic                     tick;
  logic                     go_up;
  logic                     upd;
  logic                     trig_rise;
  logic                     enc_edge;
  logic                     hall_chg;
  logic [3:0]               cap_evt;
  logic [3:0]               ccr_wr;
  logic [3:0]               ch_evt;
  logic [3:0][15:0]         ch_ccr;

  assign addr  = {avs_address[5:2], 2'h0};
  assign wmask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
                  {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};

  always_comb
  begin
    st_next = st_reg;
    st_next.step = 1'b0;
    st_next.upd = 1'b0;
    st_next.trig_out = 1'b0;
    st_next.dma_req = 1'b0;
    st_next.waitrequest = 1'b1;
    set_bits = 7'h00;
    clr_bits = 7'h00;
    tick = 1'b0;
    upd = 1'b0;
    req = avs_read | avs_write;
    acc_wr = avs_write && !st_reg.waitrequest;
    cnt_wr = acc_wr && addr == `MPCT_OFS_CNT;
    wr_word = 32'h0000_0000;
    rd_word = 32'h0000_0000;
    // reduced variants ignore the direction field
    cmode = UP_ONLY ? mpct_pkg::MPCT_CNT_UP :
      mpct_pkg::mpct_cnt_mode_t'(st_reg.ctrl[`MPCT_CTRL_MODE +: 2]);
    slv = mpct_pkg::mpct_slave_t'(st_reg.ctrl[`MPCT_CTRL_SLV +: 2]);
    trig_rise = trig_in & ~st_reg.prev_trig;
    enc_edge = enc_a ^ st_reg.prev_a;
    hall_chg = st_reg.ctrl[`MPCT_CTRL_HALL] && hall_in != st_reg.prev_hall;
    frozen = st_reg.ctrl[`MPCT_CTRL_FRZ] & dbg_halt;
    run = st_reg.ctrl[`MPCT_CTRL_EN] && !frozen;
    st_next.prev_trig = trig_in;
    st_next.prev_a = enc_a;
    st_next.prev_hall = hall_in;
    for (int i = 0; i < 4; i++)
    begin
      st_next.prev_cap[i] = (i < NUM_CH) ? cap_in[i] : 1'b0;
      cap_evt[i] = st_reg.chcfg[i][`MPCT_CFG_FALL] ?
        (st_reg.prev_cap[i] & ~st_next.prev_cap[i]) :
        (~st_reg.prev_cap[i] & st_next.prev_cap[i]);
      ccr_wr[i] = acc_wr && addr[5] && addr[4:3] == 2'(i) && addr[2];
    end
    // hall transitions time the commutation on channel 0
    if (st_reg.ctrl[`MPCT_CTRL_HALL])
      cap_evt[0] = hall_chg;

    // ----- prescaler: divide factor is psc + 1
    if (run && slv != mpct_pkg::MPCT_SLV_ENC &&
        (slv != mpct_pkg::MPCT_SLV_EXTCLK || trig_rise))
    begin
      if (st_reg.psc_cnt >= st_reg.psc)
      begin
        st_next.psc_cnt = 16'h0000;
        tick = 1'b1;
      end
      else
        st_next.psc_cnt = st_reg.psc_cnt + 16'h0001;
    end
    // encoder steps on each edge of phase a, bypassing the prescaler
    if (run && slv == mpct_pkg::MPCT_SLV_ENC && enc_edge)
      tick = 1'b1;

    // ----- counter
    if (slv == mpct_pkg::MPCT_SLV_ENC)
      go_up = enc_a ^ enc_b;
    else if (cmode == mpct_pkg::MPCT_CNT_DOWN)
      go_up = 1'b0;
    else if (cmode == mpct_pkg::MPCT_CNT_CENTER)
      go_up = st_reg.dir_up;
    else
      go_up = 1'b1;
    if (tick)
    begin
      st_next.step = 1'b1;
      if (go_up)
      begin
        if (st_reg.cnt >= st_reg.arr)
        begin
          upd = 1'b1;
          if (cmode == mpct_pkg::MPCT_CNT_CENTER &&
              slv != mpct_pkg::MPCT_SLV_ENC)
          begin
            st_next.dir_up = 1'b0;
            st_next.cnt = st_reg.arr - 16'h0001;
          end
          else
            st_next.cnt = 16'h0000;
        end
        else
          st_next.cnt = st_reg.cnt + 16'h0001;
      end
      else if (st_reg.cnt == 16'h0000)
      begin
        upd = 1'b1;
        if (cmode == mpct_pkg::MPCT_CNT_CENTER &&
            slv != mpct_pkg::MPCT_SLV_ENC)
        begin
          st_next.dir_up = 1'b1;
          st_next.cnt = 16'h0001;
        end
        else
          st_next.cnt = st_reg.arr;
      end
      else
        st_next.cnt = st_reg.cnt - 16'h0001;
    end
    if (upd)
    begin
      st_next.upd = 1'b1;
      st_next.trig_out = 1'b1;
      set_bits[`MPCT_ST_UPD] = 1'b1;
      if (st_reg.ctrl[`MPCT_CTRL_OPM])
        st_next.ctrl[`MPCT_CTRL_EN] = 1'b0;
    end
    if (trig_rise)
    begin
      set_bits[`MPCT_ST_TRG] = 1'b1;
      if (slv == mpct_pkg::MPCT_SLV_TRIG)
        st_next.ctrl[`MPCT_CTRL_EN] = 1'b1;
    end
    set_bits[`MPCT_ST_HALL] = hall_chg;
    set_bits[`MPCT_ST_CH +: 4] = ch_evt;

    // ----- register read
    case (addr)
      `MPCT_OFS_CTRL: rd_word[7:0] = st_reg.ctrl;
      `MPCT_OFS_STAT: rd_word[6:0] = st_reg.status;
      `MPCT_OFS_MASK: rd_word[6:0] = st_reg.mask;
      `MPCT_OFS_DMAE: rd_word[6:0] = st_reg.dmaen;
      `MPCT_OFS_CNT:  rd_word[15:0] = st_reg.cnt;
      `MPCT_OFS_PSC:  rd_word[15:0] = st_reg.psc;
      `MPCT_OFS_ARR:  rd_word[15:0] = st_reg.arr;
      `MPCT_OFS_DEAD: rd_word[7:0] = st_reg.dead;
      default:
      begin
        if (addr[5] && int'(addr[4:3]) < NUM_CH)
        begin
          if (addr[2])
            rd_word[15:0] = ch_ccr[addr[4:3]];
          else
            rd_word[4:0] = st_reg.chcfg[addr[4:3]];
        end
      end
    endcase
    // ----- register write, at the edge that ends the wait
    wr_word = (rd_word & ~wmask) | (avs_writedata & wmask);
    if (acc_wr)
    begin
      case (addr)
        `MPCT_OFS_CTRL: st_next.ctrl = wr_word[7:0];
        `MPCT_OFS_STAT: clr_bits = avs_writedata[6:0] & wmask[6:0];
        `MPCT_OFS_MASK: st_next.mask = wr_word[6:0];
        `MPCT_OFS_DMAE: st_next.dmaen = wr_word[6:0];
        `MPCT_OFS_CNT:  st_next.cnt = wr_word[15:0];
        `MPCT_OFS_PSC:  st_next.psc = wr_word[15:0];
        `MPCT_OFS_ARR:  st_next.arr = wr_word[15:0];
        `MPCT_OFS_DEAD: st_next.dead = wr_word[7:0];
        default:
        begin
          if (addr[5] && !addr[2] && int'(addr[4:3]) < NUM_CH)
            st_next.chcfg[addr[4:3]] = wr_word[4:0];
        end
      endcase
    end
    // ----- bus answer one cycle after the request is seen
    if (req && st_reg.waitrequest)
    begin
      st_next.waitrequest = 1'b0;
      st_next.rdata = rd_word;
    end
    // a new event wins over a clear in the same cycle
    st_next.status = (st_reg.status & ~clr_bits) | set_bits;
    st_next.irq = |(st_next.status & st_next.mask);
    st_next.dma_req = |(set_bits & st_reg.dmaen);
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_reg <= '0;
      st_reg.ctrl <= `MPCT_RST_CTRL;
      st_reg.arr <= `MPCT_RST_ARR;
      st_reg.psc <= `MPCT_RST_PSC;
      st_reg.dead <= `MPCT_RST_DEAD;
      st_reg.dir_up <= 1'b1;
      st_reg.waitrequest <= 1'b1;
    end
    else
      st_reg <= st_next;
  end

  // ============================================================
  // channels
  generate
    for (genvar g = 0; g < 4; g++)
    begin : g_ch
      if (g < NUM_CH)
      begin : g_on
        mpct_channel #(
          .HAS_COMP (HAS_COMP)
        ) u_ch (
          .clk       (clk),
          .rst_n     (rst_n),
          .mode      (mpct_pkg::mpct_ch_mode_t'(st_reg.chcfg[g][1:0])),
          .pol       (st_reg.chcfg[g][`MPCT_CFG_POL]),
          .oe        (st_reg.chcfg[g][`MPCT_CFG_OE]),
          .dead      (st_reg.dead),
          .cnt       (st_reg.cnt),
          .step      (st_reg.step),
          .upd       (st_reg.upd),
          .cap_evt   (cap_evt[g]),
          .ccr_wr    (ccr_wr[g]),
          .ccr_wdata (wr_word[15:0]),
          .ccr       (ch_ccr[g]),
          .evt       (ch_evt[g]),
          .out_p     (ch_out[g]),
          .out_n     (ch_out_n[g])
        );
      end
      else
      begin : g_off
        assign ch_ccr[g] = 16'h0000;
        assign ch_evt[g] = 1'b0;
      end
    end
  endgenerate

  assign avs_readdata    = st_reg.rdata;
  assign avs_waitrequest = st_reg.waitrequest;
  assign irq             = st_reg.irq;
  assign dma_req         = st_reg.dma_req;
  assign trig_out        = st_reg.trig_out;

  // ============================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_trig_start;
    slv == mpct_pkg::MPCT_SLV_TRIG && trig_rise && !acc_wr;
  endsequence

  a_bus_answer: assert property (req && st_reg.waitrequest
    |=> !st_reg.waitrequest)
    else $error("bus request not answered in one cycle");
  a_up_wrap: assert property (tick && go_up && !cnt_wr &&
    cmode == mpct_pkg::MPCT_CNT_UP && st_reg.cnt == st_reg.arr
    |=> st_reg.cnt == 16'h0000 && st_reg.upd && st_reg.trig_out)
    else $error("up count did not wrap with update");
  a_psc_tick: assert property (tick &&
    slv != mpct_pkg::MPCT_SLV_ENC |=> st_reg.psc_cnt == 16'h0000)
    else $error("prescaler did not restart on tick");
  a_center_turn: assert property (tick && go_up && !cnt_wr &&
    cmode == mpct_pkg::MPCT_CNT_CENTER && slv != mpct_pkg::MPCT_SLV_ENC &&
    st_reg.cnt == st_reg.arr |=> !st_reg.dir_up)
    else $error("center mode did not turn down at reload");
  a_freeze_hold: assert property (frozen && !cnt_wr
    |=> $stable(st_reg.cnt))
    else $error("counter moved during debug halt");
  a_dma_pulse: assert property (st_reg.upd &&
    $past(st_reg.dmaen[`MPCT_ST_UPD]) |-> st_reg.dma_req)
    else $error("update gave no dma request");
  a_enc_up: assert property (run && slv == mpct_pkg::MPCT_SLV_ENC &&
    enc_a && !st_reg.prev_a && !enc_b && !cnt_wr &&
    st_reg.cnt < st_reg.arr |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
    else $error("encoder forward edge did not count up");
  a_hall_flag: assert property (hall_chg
    |=> st_reg.status[`MPCT_ST_HALL])
    else $error("hall change not flagged");
  a_trig_start: assert property (s_trig_start
    |=> st_reg.ctrl[`MPCT_CTRL_EN])
    else $error("trigger did not start the counter");
  a_up_only: assert property (UP_ONLY && tick && !cnt_wr &&
    slv != mpct_pkg::MPCT_SLV_ENC && st_reg.cnt < st_reg.arr
    |=> st_reg.cnt == $past(st_reg.cnt) + 16'h0001)
    else $error("reduced variant did not count up");
endmodule

/* testbench/mpct_far_side.sv */
// far side model: quadrature encoder and hall sensor set
`timescale 1ns/1ps
module mpct_far_side (
  input  logic       clk,
  output logic       enc_a,
  output logic       enc_b,
  output logic [2:0] hall_in
);
  initial
  begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    hall_in = 3'h1;
  end
  // phase b settles first, then the a edge carries the step
  task automatic enc_step(input logic up);
    enc_b <= !enc_a ^ up;
    repeat (3) @(posedge clk);
    enc_a <= !enc_a;
    repeat (3) @(posedge clk);
  endtask
  // one commutation step of the sensor code
  task automatic hall_step;
    hall_in <= {hall_in[1:0], hall_in[2]};
    repeat (3) @(posedge clk);
  endtask
endmodule

/* testbench/tb_top.sv */
// self-checking bench for the multichannel timer
`timescale 1ns/1ps
`include "mpct_regs.svh"
module tb_top;
  logic        clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        enc_a;
  logic        enc_b;
  logic [2:0]  hall_in;
  logic        trig_in = 1'b0;
  logic [3:0]  cap_in = 4'h0;
  logic        dbg_halt = 1'b0;
  logic [3:0]  ch_out;
  logic [3:0]  ch_out_n;
  logic        irq;
  logic        dma_req;
  logic        trig_out;
  logic [31:0] r;
  int          error_cnt = 0;
  int          checks = 0;
  always #5 clk = ~clk;
  mpct_timer u_mpct_timer (.clk(clk), .arst_n(arst_n),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .cap_in(cap_in), .enc_a(enc_a),
    .enc_b(enc_b), .hall_in(hall_in), .trig_in(trig_in),
    .dbg_halt(dbg_halt), .ch_out(ch_out), .ch_out_n(ch_out_n),
    .irq(irq), .dma_req(dma_req), .trig_out(trig_out));
  mpct_far_side u_mpct_far_side (.clk(clk), .enc_a(enc_a),
    .enc_b(enc_b), .hall_in(hall_in));
  // ====================
  // shared tasks
  task automatic end_sim;
    if (error_cnt == 0 && checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // holds the request until waitrequest is seen low at an edge;
  // a hang is left to the watchdog
  task automatic bus(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // one idle edge so a following call never re-drives in this step
    @(posedge clk);
  endtask
  task automatic rchk(input logic [5:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    cmp(r, exp);
  endtask
  // cycles from one update pulse to the next
  task automatic period(output int p);
    int n = 0;
    while (trig_out !== 1'b1 && n < 300)
    begin
      @(posedge clk);
      n++;
    end
    @(posedge clk);
    p = 1;
    while (trig_out !== 1'b1 && p < 300)
    begin
      @(posedge clk);
      p++;
    end
  endtask
  task automatic pwm_chk(input logic [15:0] v, input int em,
                         input int ec);
    int m = 0;
    int c = 0;
    int b = 0;
    bus(1'b1, `MPCT_OFS_CH + 6'h04, {16'h0, v});
    repeat (40) @(posedge clk);
    repeat (16)
    begin
      @(posedge clk);
      m += int'(ch_out[0] === 1'b1);
      c += int'(ch_out_n[0] === 1'b1);
      b += int'(ch_out[0] !== 1'b0 && ch_out_n[0] !== 1'b0);
    end
    cmp(32'(m), 32'(em));
    cmp(32'(c), 32'(ec));
    cmp(32'(b), 32'h0);
  endtask
  // ====================
  // scenarios
  task automatic t_regs;
    rchk(`MPCT_OFS_CTRL, 32'h0);
    rchk(`MPCT_OFS_ARR, 32'h0000FFFF);
    rchk(`MPCT_OFS_PSC, 32'h0);
    bus(1'b1, `MPCT_OFS_DEAD, 32'hFFFFFFFF);
    rchk(`MPCT_OFS_DEAD, 32'h000000FF);
    bus(1'b1, `MPCT_OFS_PSC, 32'h0001FFFF);
    rchk(`MPCT_OFS_PSC, 32'h0000FFFF);
  endtask
  task automatic t_up;
    int p;
    bus(1'b1, `MPCT_OFS_ARR, 32'h3);
    bus(1'b1, `MPCT_OFS_PSC, 32'h1);
    bus(1'b1, `MPCT_OFS_MASK, 32'h1);
    bus(1'b1, `MPCT_OFS_DMAE, 32'h1);
    bus(1'b1, `MPCT_OFS_CTRL, 32'h1);
    period(p);
    cmp({31'h0, dma_req}, 32'h1);
    cmp(32'(p), 32'h8);
    repeat (3) @(posedge clk);
    cmp({31'h0, irq}, 32'h1);
    bus(1'b1, `MPCT_OFS_CTRL, 32'h0);
    bus(1'b1, `MPCT_OFS_STAT, 32'h7F);
    rchk(`MPCT_OFS_STAT, 32'h0);
    cmp({31'h0, irq}, 32'h0);
  endtask
  task automatic t_modes;
    int p;
    bus(1'b1, `MPCT_OFS_PSC, 32'h0);
    for (int m = 1; m < 3; m++)
    begin
      bus(1'b1, `MPCT_OFS_CTRL, 32'(2 * m + 1));
      period(p);
      cmp(32'(p), 32'(5 - m));
    end
    bus(1'b1, `MPCT_OFS_CTRL, 32'h0);
  endtask
  task automatic t_freeze;
    logic [31:0] a;
    bus(1'b1, `MPCT_OFS_ARR, 32'hFFFF);
    dbg_halt <= 1'b1;
    bus(1'b1, `MPCT_OFS_CTRL, 32'h9);
    bus(1'b0, `MPCT_OFS_CNT, 32'h0);
    a = r;
    repeat (5) @(posedge clk);
    rchk(`MPCT_OFS_CNT, a);
    dbg_halt <= 1'b0;
    repeat (5) @(posedge clk);
    bus(1'b0, `MPCT_OFS_CNT, 32'h0);
    cmp({31'h0, r > a}, 32'h1);
    bus(1'b1, `MPCT_OFS_CTRL, 32'h0);
  endtask
  task automatic t_pwm;
    bus(1'b1, `MPCT_OFS_ARR, 32'hF);
    bus(1'b1, `MPCT_OFS_DEAD, 32'h2);
    bus(1'b1, `MPCT_OFS_CH, 32'h12);
    bus(1'b1, `MPCT_OFS_CTRL, 32'h1);
    pwm_chk(16'h8, 5, 5);
    pwm_chk(16'h0, 0, 16);
    pwm_chk(16'h10, 16, 0);
    bus(1'b1, `MPCT_OFS_CTRL, 32'h0);
  endtask
  task automatic t_link;
    bus(1'b1, `MPCT_OFS_CTRL, 32'h31);
    bus(1'b1, `MPCT_OFS_CNT, 32'hA);
    repeat (4) u_mpct_far_side.enc_step(1'b1);
    repeat (2) u_mpct_far_side.enc_step(1'b0);
    rchk(`MPCT_OFS_CNT, 32'hC);
    bus(1'b1, `MPCT_OFS_CTRL, 32'hA1);
    bus(1'b1, `MPCT_OFS_CNT, 32'h0);
    bus(1'b1, `MPCT_OFS_CH, 32'h0);
    bus(1'b1, `MPCT_OFS_STAT, 32'h7F);
    repeat (5)
    begin
      trig_in <= 1'b1;
      repeat (2) @(posedge clk);
      trig_in <= 1'b0;
      repeat (2) @(posedge clk);
    end
    u_mpct_far_side.hall_step();
    rchk(`MPCT_OFS_CNT, 32'h5);
    rchk(`MPCT_OFS_CH + 6'h04, 32'h5);
    bus(1'b0, `MPCT_OFS_STAT, 32'h0);
    cmp(r & 32'h60, 32'h60);
  endtask
  task automatic t_cap;
    bus(1'b1, `MPCT_OFS_CTRL, 32'h0);
    bus(1'b1, `MPCT_OFS_CNT, 32'h7);
    bus(1'b1, `MPCT_OFS_CH + 6'h08, 32'h08);
    bus(1'b1, `MPCT_OFS_STAT, 32'h7F);
    cap_in <= 4'h2;
    repeat (2) @(posedge clk);
    cap_in <= 4'h0;
    repeat (4) @(posedge clk);
    rchk(`MPCT_OFS_CH + 6'h0C, 32'h7);
    rchk(`MPCT_OFS_STAT, 32'h4);
  endtask
  // trigger start with one-pulse stop; ch2 one-pulse, ch3 compare
  task automatic t_trig;
    bus(1'b1, `MPCT_OFS_ARR, 32'h3);
    bus(1'b1, `MPCT_OFS_CNT, 32'h0);
    bus(1'b1, `MPCT_OFS_CH + 6'h10, 32'h3);
    bus(1'b1, `MPCT_OFS_CH + 6'h14, 32'h1);
    bus(1'b1, `MPCT_OFS_CH + 6'h18, 32'h1);
    bus(1'b1, `MPCT_OFS_CH + 6'h1C, 32'h2);
    bus(1'b1, `MPCT_OFS_CTRL, 32'h50);
    bus(1'b1, `MPCT_OFS_STAT, 32'h7F);
    trig_in <= 1'b1;
    repeat (12) @(posedge clk);
    trig_in <= 1'b0;
    rchk(`MPCT_OFS_CTRL, 32'h50);
    rchk(`MPCT_OFS_CNT, 32'h0);
    bus(1'b0, `MPCT_OFS_STAT, 32'h0);
    cmp(r & 32'h39, 32'h39);
  endtask
  // ====================
  // main sequence and watchdog
  initial
  begin
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_regs();
    t_up();
    t_modes();
    t_freeze();
    t_pwm();
    t_link();
    t_cap();
    t_trig();
    end_sim();
  end
  // far above the several hundred cycles the scenarios need
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    end_sim();
  end
endmodule
